// *** rtl/limit_monitor_pkg.sv ***
// Constants for the limit, fault and warning monitor
package limit_monitor_pkg;

   // ************************************************************
   // Command codes on the management command port
   // ************************************************************
   localparam logic [7:0] CMD_CLEAR_FAULTS       = 8'h01;
   localparam logic [7:0] CMD_IOUT_OC_WARN_LIM   = 8'h10;
   localparam logic [7:0] CMD_IOUT_SINK_FLT_LIM  = 8'h11;
   localparam logic [7:0] CMD_IOUT_SINK_FLT_ACT  = 8'h12;
   localparam logic [7:0] CMD_OT_FLT_LIM         = 8'h20;
   localparam logic [7:0] CMD_OT_FLT_ACT         = 8'h21;
   localparam logic [7:0] CMD_OT_WARN_LIM        = 8'h22;
   localparam logic [7:0] CMD_UT_WARN_LIM        = 8'h23;
   localparam logic [7:0] CMD_UT_FLT_LIM         = 8'h24;
   localparam logic [7:0] CMD_UT_FLT_ACT         = 8'h25;
   localparam logic [7:0] CMD_VIN_OV_FLT_LIM     = 8'h30;
   localparam logic [7:0] CMD_VIN_OV_FLT_ACT     = 8'h31;
   localparam logic [7:0] CMD_VIN_HI_WARN_LIM    = 8'h32;
   localparam logic [7:0] CMD_VIN_LO_WARN_LIM    = 8'h33;
   localparam logic [7:0] CMD_VIN_UV_FLT_LIM     = 8'h34;
   localparam logic [7:0] CMD_STATUS_BYTE        = 8'h40;
   localparam logic [7:0] CMD_STATUS_WORD        = 8'h41;
   localparam logic [7:0] CMD_STATUS_IOUT        = 8'h42;
   localparam logic [7:0] CMD_STATUS_TEMP        = 8'h43;
   localparam logic [7:0] CMD_STATUS_INPUT       = 8'h44;

   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [15:0] RST_IOUT_OC_WARN_LIM  = 16'h7fff;
   localparam logic [15:0] RST_IOUT_SINK_FLT_LIM = 16'h0000;
   localparam logic [15:0] RST_OT_FLT_LIM        = 16'h7fff;
   localparam logic [15:0] RST_OT_WARN_LIM       = 16'h7fff;
   localparam logic [15:0] RST_UT_WARN_LIM       = 16'h8000;
   localparam logic [15:0] RST_UT_FLT_LIM        = 16'h8000;
   localparam logic [15:0] RST_VIN_OV_FLT_LIM    = 16'hffff;
   localparam logic [15:0] RST_VIN_HI_WARN_LIM   = 16'hffff;
   localparam logic [15:0] RST_VIN_LO_WARN_LIM   = 16'h0000;
   localparam logic [15:0] RST_VIN_UV_FLT_LIM    = 16'h0000;
   localparam logic [7:0]  RST_FLT_ACT           = 8'h00;

   // ************************************************************
   // Status bit positions
   // ************************************************************
   localparam int SB_NONE_ABOVE = 0;
   localparam int SB_TEMP       = 2;
   localparam int SW_INPUT      = 13;
   localparam int SW_IOUT       = 14;
   localparam int SI_OC_WARN    = 5;
   localparam int SI_SINK_FLT   = 4;
   localparam int ST_OT_FLT     = 7;
   localparam int ST_OT_WARN    = 6;
   localparam int ST_UT_WARN    = 5;
   localparam int ST_UT_FLT     = 4;
   localparam int SV_OV_FLT     = 7;
   localparam int SV_OV_WARN    = 6;
   localparam int SV_UV_WARN    = 5;
   localparam int SV_UV_FLT     = 4;

   // ************************************************************
   // Fault action field
   // ************************************************************
   localparam int ACT_MODE_HI = 7;
   localparam int ACT_MODE_LO = 6;
   localparam logic [1:0] ACT_IGNORE = 2'h0;
   localparam logic [1:0] ACT_CC_RUN = 2'h1;

endpackage

// *** rtl/limit_fault_warning_monitor.sv ***
// Limit comparison, sticky status and fault action logic of the monitor
//
// Function
// - Output current above warning limit sets current warning status and warns host.
// - Each limit is sixteen bits, signed for current and temperature, unsigned for input voltage.
// - Sourcing current counts positive, sinking current counts negative.
// - Sink current fault limit resets to zero amperes.
// - Sink fault inhibit stops only synchronous rectification, not energy transfer.
// - Sink current fault sets current fault status, applies action, notifies host.
// - Sink action uses current encoding; temperature and input use general encoding.
// - Overtemperature fault sets temperature status, applies action, notifies host.
// - Overtemperature warning sets temperature status and warns host.
// - Undertemperature warning sets temperature status and warns host.
// - Undertemperature fault sets temperature status, applies action, notifies host.
// - Input overvoltage fault sets input status, applies action, notifies host.
// - Input high warning sets input status and warns host.
// - Input low warning sets input status and warns host.
// - Input undervoltage checks wait for turn-on threshold and unit enable.
// - Temperature compared in degrees Celsius, current in amperes.
// - Clear faults clears all status at once and releases alert.
// - A condition still present after clear sets its bit again.
// - Status bits stay set until the host clears them.
`timescale 1ns/100ps
`default_nettype none

module limit_fault_warning_monitor (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   output var  logic        rsp_valid,
   output var  logic        rsp_error,
   output var  logic [15:0] rsp_rdata,
   input  wire logic        iout_valid,
   input  wire logic [15:0] iout_sample,
   input  wire logic        temp_valid,
   input  wire logic [15:0] temp_sample,
   input  wire logic        vin_valid,
   input  wire logic [15:0] vin_sample,
   input  wire logic        vin_above_on,
   input  wire logic        unit_enabled,
   output var  logic        alert_n,
   output var  logic        warn_notify,
   output var  logic        fault_notify,
   output var  logic        sync_rect_inhibit,
   output var  logic        output_inhibit
);

   // ************************************************************
   // Decode helpers
   // ************************************************************
   // General fault byte: any mode but ignore inhibits the unit
   function automatic logic gen_inhibit(input logic [7:0] act);
      gen_inhibit = act[limit_monitor_pkg::ACT_MODE_HI:limit_monitor_pkg::ACT_MODE_LO]
                    != limit_monitor_pkg::ACT_IGNORE;
   endfunction

   function automatic logic is_write(input logic [7:0] code, input logic [7:0] want);
      is_write = (code == want);
   endfunction

   // ************************************************************
   // Limit and action registers
   // ************************************************************
   logic [15:0] iout_oc_warn_lim;
   logic [15:0] iout_sink_flt_lim;
   logic [7:0]  iout_sink_flt_act;
   logic [15:0] ot_flt_lim;
   logic [7:0]  ot_flt_act;
   logic [15:0] ot_warn_lim;
   logic [15:0] ut_warn_lim;
   logic [15:0] ut_flt_lim;
   logic [7:0]  ut_flt_act;
   logic [15:0] vin_ov_flt_lim;
   logic [7:0]  vin_ov_flt_act;
   logic [15:0] vin_hi_warn_lim;
   logic [15:0] vin_lo_warn_lim;
   logic [15:0] vin_uv_flt_lim;

   wire wr_en = cmd_valid & cmd_write;
   // Sixteen-bit limits, fixed format per limit
   always_ff @(posedge core_clk) begin
      if (rst) begin
         iout_oc_warn_lim  <= limit_monitor_pkg::RST_IOUT_OC_WARN_LIM;
         iout_sink_flt_lim <= limit_monitor_pkg::RST_IOUT_SINK_FLT_LIM;
         iout_sink_flt_act <= limit_monitor_pkg::RST_FLT_ACT;
         ot_flt_lim        <= limit_monitor_pkg::RST_OT_FLT_LIM;
         ot_flt_act        <= limit_monitor_pkg::RST_FLT_ACT;
         ot_warn_lim       <= limit_monitor_pkg::RST_OT_WARN_LIM;
         ut_warn_lim       <= limit_monitor_pkg::RST_UT_WARN_LIM;
         ut_flt_lim        <= limit_monitor_pkg::RST_UT_FLT_LIM;
         ut_flt_act        <= limit_monitor_pkg::RST_FLT_ACT;
         vin_ov_flt_lim    <= limit_monitor_pkg::RST_VIN_OV_FLT_LIM;
         vin_ov_flt_act    <= limit_monitor_pkg::RST_FLT_ACT;
         vin_hi_warn_lim   <= limit_monitor_pkg::RST_VIN_HI_WARN_LIM;
         vin_lo_warn_lim   <= limit_monitor_pkg::RST_VIN_LO_WARN_LIM;
         vin_uv_flt_lim    <= limit_monitor_pkg::RST_VIN_UV_FLT_LIM;
      end else if (wr_en) begin
         if (is_write(cmd_code, limit_monitor_pkg::CMD_IOUT_OC_WARN_LIM)) begin
            iout_oc_warn_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_IOUT_SINK_FLT_LIM)) begin
            iout_sink_flt_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_IOUT_SINK_FLT_ACT)) begin
            iout_sink_flt_act <= cmd_wdata[7:0];
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_OT_FLT_LIM)) begin
            ot_flt_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_OT_FLT_ACT)) begin
            ot_flt_act <= cmd_wdata[7:0];
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_OT_WARN_LIM)) begin
            ot_warn_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_UT_WARN_LIM)) begin
            ut_warn_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_UT_FLT_LIM)) begin
            ut_flt_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_UT_FLT_ACT)) begin
            ut_flt_act <= cmd_wdata[7:0];
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_VIN_OV_FLT_LIM)) begin
            vin_ov_flt_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_VIN_OV_FLT_ACT)) begin
            vin_ov_flt_act <= cmd_wdata[7:0];
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_VIN_HI_WARN_LIM)) begin
            vin_hi_warn_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_VIN_LO_WARN_LIM)) begin
            vin_lo_warn_lim <= cmd_wdata;
         end
         if (is_write(cmd_code, limit_monitor_pkg::CMD_VIN_UV_FLT_LIM)) begin
            vin_uv_flt_lim <= cmd_wdata;
         end
      end
   end

   // ************************************************************
   // Comparators
   // ************************************************************
   // Signed current, sink is negative
   // Current in amperes, temperature in Celsius, both signed
   wire signed [15:0] iout_s = $signed(iout_sample);
   wire signed [15:0] temp_s = $signed(temp_sample);
   logic              uv_armed;

   // Compare only on a fresh sample
   wire c_oc_warn   = iout_valid & (iout_s > $signed(iout_oc_warn_lim));
   wire c_sink_flt  = iout_valid & (iout_s < $signed(iout_sink_flt_lim));
   wire c_ot_flt    = temp_valid & (temp_s > $signed(ot_flt_lim));
   wire c_ot_warn   = temp_valid & (temp_s > $signed(ot_warn_lim));
   wire c_ut_warn   = temp_valid & (temp_s < $signed(ut_warn_lim));
   wire c_ut_flt    = temp_valid & (temp_s < $signed(ut_flt_lim));
   wire c_vin_ov_f  = vin_valid & (vin_sample > vin_ov_flt_lim);
   wire c_vin_hi_w  = vin_valid & (vin_sample > vin_hi_warn_lim);
   wire c_vin_lo_w  = vin_valid & uv_armed & (vin_sample < vin_lo_warn_lim);
   wire c_vin_uv_f  = vin_valid & uv_armed & (vin_sample < vin_uv_flt_lim);

   // ************************************************************
   // Undervoltage arming
   // ************************************************************
   // Disarms on disable so a normal power-down ramp raises no alarm
   wire  next_uv_armed = unit_enabled & (uv_armed | vin_above_on);

   // Arm after turn-on level and enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         uv_armed <= 1'b0;
      end else begin
         uv_armed <= next_uv_armed;
      end
   end

   // ************************************************************
   // Sticky detailed status
   // ************************************************************
   logic [7:0] stat_iout;
   logic [7:0] stat_temp;
   logic [7:0] stat_input;

   wire clear_cmd = wr_en & is_write(cmd_code, limit_monitor_pkg::CMD_CLEAR_FAULTS);
   logic [7:0] set_iout;
   logic [7:0] set_temp;
   logic [7:0] set_input;

   always_comb begin
      set_iout = 8'h00;
      set_iout[limit_monitor_pkg::SI_OC_WARN]  = c_oc_warn;
      set_iout[limit_monitor_pkg::SI_SINK_FLT] = c_sink_flt;
   end

   always_comb begin
      set_temp = 8'h00;
      set_temp[limit_monitor_pkg::ST_OT_FLT]  = c_ot_flt;
      set_temp[limit_monitor_pkg::ST_OT_WARN] = c_ot_warn;
      set_temp[limit_monitor_pkg::ST_UT_WARN] = c_ut_warn;
      set_temp[limit_monitor_pkg::ST_UT_FLT]  = c_ut_flt;
   end

   always_comb begin
      set_input = 8'h00;
      set_input[limit_monitor_pkg::SV_OV_FLT]  = c_vin_ov_f;
      set_input[limit_monitor_pkg::SV_OV_WARN] = c_vin_hi_w;
      set_input[limit_monitor_pkg::SV_UV_WARN] = c_vin_lo_w;
      set_input[limit_monitor_pkg::SV_UV_FLT]  = c_vin_uv_f;
   end

   // Set wins over a same-cycle clear
   wire [7:0] next_stat_iout  = set_iout  | (clear_cmd ? 8'h00 : stat_iout);
   wire [7:0] next_stat_temp  = set_temp  | (clear_cmd ? 8'h00 : stat_temp);
   wire [7:0] next_stat_input = set_input | (clear_cmd ? 8'h00 : stat_input);

   // Newly raised bits, including a bit raised again right after clear
   wire [7:0] rise_iout  = set_iout  & (clear_cmd ? 8'hff : ~stat_iout);
   wire [7:0] rise_temp  = set_temp  & (clear_cmd ? 8'hff : ~stat_temp);
   wire [7:0] rise_input = set_input & (clear_cmd ? 8'hff : ~stat_input);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stat_iout  <= 8'h00;
         stat_temp  <= 8'h00;
         stat_input <= 8'h00;
      end else begin
         stat_iout  <= next_stat_iout;
         stat_temp  <= next_stat_temp;
         stat_input <= next_stat_input;
      end
   end

   // ************************************************************
   // Summary status
   // ************************************************************
   // Summaries follow the detailed bits, so one clear covers all of them
   wire iout_any  = |stat_iout;
   wire temp_any  = |stat_temp;
   wire input_any = |stat_input;

   logic [7:0]  stat_byte;
   logic [15:0] stat_word;

   // Summary bits for current, temperature and input events
   always_comb begin
      stat_byte = 8'h00;
      stat_byte[limit_monitor_pkg::SB_NONE_ABOVE] = iout_any | input_any;
      stat_byte[limit_monitor_pkg::SB_TEMP]       = temp_any;
      stat_word = {8'h00, stat_byte};
      stat_word[limit_monitor_pkg::SW_IOUT]  = iout_any;
      stat_word[limit_monitor_pkg::SW_INPUT] = input_any;
   end

   // ************************************************************
   // Host notification
   // ************************************************************
   wire warn_rise = rise_iout[limit_monitor_pkg::SI_OC_WARN] |
                    rise_temp[limit_monitor_pkg::ST_OT_WARN] |
                    rise_temp[limit_monitor_pkg::ST_UT_WARN] |
                    rise_input[limit_monitor_pkg::SV_OV_WARN] |
                    rise_input[limit_monitor_pkg::SV_UV_WARN];
   wire fault_rise = rise_iout[limit_monitor_pkg::SI_SINK_FLT] |
                     rise_temp[limit_monitor_pkg::ST_OT_FLT] |
                     rise_temp[limit_monitor_pkg::ST_UT_FLT] |
                     rise_input[limit_monitor_pkg::SV_OV_FLT] |
                     rise_input[limit_monitor_pkg::SV_UV_FLT];
   wire next_alert_n = ~(|{next_stat_iout, next_stat_temp, next_stat_input});

   always_ff @(posedge core_clk) begin
      if (rst) begin
         alert_n      <= 1'b1;
         warn_notify  <= 1'b0;
         fault_notify <= 1'b0;
      end else begin
         alert_n      <= next_alert_n;
         warn_notify  <= warn_rise;
         fault_notify <= fault_rise;
      end
   end

   // ************************************************************
   // Fault actions
   // ************************************************************
   // Current encoding: ignore and constant current keep rectifying
   wire sink_mode_stop = iout_sink_flt_act[limit_monitor_pkg::ACT_MODE_HI:limit_monitor_pkg::ACT_MODE_LO]
                         != limit_monitor_pkg::ACT_IGNORE &&
                         iout_sink_flt_act[limit_monitor_pkg::ACT_MODE_HI:limit_monitor_pkg::ACT_MODE_LO]
                         != limit_monitor_pkg::ACT_CC_RUN;

   // General encoding for temperature and input faults
   wire gen_trip = (c_ot_flt & gen_inhibit(ot_flt_act)) |
                   (c_ut_flt & gen_inhibit(ut_flt_act)) |
                   (c_vin_ov_f & gen_inhibit(vin_ov_flt_act));

   // Latched off until the unit is disabled; clear faults does not restart it
   wire next_sync_rect_inhibit = unit_enabled & (sync_rect_inhibit | (c_sink_flt & sink_mode_stop));
   wire next_output_inhibit    = unit_enabled & (output_inhibit | gen_trip);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_rect_inhibit <= 1'b0;
         output_inhibit    <= 1'b0;
      end else begin
         sync_rect_inhibit <= next_sync_rect_inhibit;
         output_inhibit    <= next_output_inhibit;
      end
   end

   // ************************************************************
   // Command read path
   // ************************************************************
   wire c = cmd_code == limit_monitor_pkg::CMD_CLEAR_FAULTS;
   wire [15:0] rd_mux =
      (cmd_code == limit_monitor_pkg::CMD_IOUT_OC_WARN_LIM)  ? iout_oc_warn_lim :
      (cmd_code == limit_monitor_pkg::CMD_IOUT_SINK_FLT_LIM) ? iout_sink_flt_lim :
      (cmd_code == limit_monitor_pkg::CMD_IOUT_SINK_FLT_ACT) ? {8'h00, iout_sink_flt_act} :
      (cmd_code == limit_monitor_pkg::CMD_OT_FLT_LIM)        ? ot_flt_lim :
      (cmd_code == limit_monitor_pkg::CMD_OT_FLT_ACT)        ? {8'h00, ot_flt_act} :
      (cmd_code == limit_monitor_pkg::CMD_OT_WARN_LIM)       ? ot_warn_lim :
      (cmd_code == limit_monitor_pkg::CMD_UT_WARN_LIM)       ? ut_warn_lim :
      (cmd_code == limit_monitor_pkg::CMD_UT_FLT_LIM)        ? ut_flt_lim :
      (cmd_code == limit_monitor_pkg::CMD_UT_FLT_ACT)        ? {8'h00, ut_flt_act} :
      (cmd_code == limit_monitor_pkg::CMD_VIN_OV_FLT_LIM)    ? vin_ov_flt_lim :
      (cmd_code == limit_monitor_pkg::CMD_VIN_OV_FLT_ACT)    ? {8'h00, vin_ov_flt_act} :
      (cmd_code == limit_monitor_pkg::CMD_VIN_HI_WARN_LIM)   ? vin_hi_warn_lim :
      (cmd_code == limit_monitor_pkg::CMD_VIN_LO_WARN_LIM)   ? vin_lo_warn_lim :
      (cmd_code == limit_monitor_pkg::CMD_VIN_UV_FLT_LIM)    ? vin_uv_flt_lim :
      (cmd_code == limit_monitor_pkg::CMD_STATUS_BYTE)       ? {8'h00, stat_byte} :
      (cmd_code == limit_monitor_pkg::CMD_STATUS_WORD)       ? stat_word :
      (cmd_code == limit_monitor_pkg::CMD_STATUS_IOUT)       ? {8'h00, stat_iout} :
      (cmd_code == limit_monitor_pkg::CMD_STATUS_TEMP)       ? {8'h00, stat_temp} :
      (cmd_code == limit_monitor_pkg::CMD_STATUS_INPUT)      ? {8'h00, stat_input} :
      16'h0000;

   // Status codes are read only; clear faults is write only
   wire is_status = (cmd_code >= limit_monitor_pkg::CMD_STATUS_BYTE) &&
                    (cmd_code <= limit_monitor_pkg::CMD_STATUS_INPUT);
   wire is_limit  = (rd_mux != 16'h0000) | (cmd_code == limit_monitor_pkg::CMD_IOUT_OC_WARN_LIM) |
                    ((cmd_code >= limit_monitor_pkg::CMD_IOUT_SINK_FLT_LIM) &&
                     (cmd_code <= limit_monitor_pkg::CMD_IOUT_SINK_FLT_ACT)) |
                    ((cmd_code >= limit_monitor_pkg::CMD_OT_FLT_LIM) &&
                     (cmd_code <= limit_monitor_pkg::CMD_UT_FLT_ACT)) |
                    ((cmd_code >= limit_monitor_pkg::CMD_VIN_OV_FLT_LIM) &&
                     (cmd_code <= limit_monitor_pkg::CMD_VIN_UV_FLT_LIM));
   wire next_rsp_error = cmd_write ? ~(c | (is_limit & ~is_status)) : ~(is_status | (is_limit & ~c));
   wire [15:0] next_rsp_rdata = (cmd_write | next_rsp_error) ? 16'h0000 : rd_mux;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_error <= 1'b0;
         rsp_rdata <= 16'h0000;
      end else begin
         rsp_valid <= cmd_valid;
         rsp_error <= cmd_valid & next_rsp_error;
         rsp_rdata <= cmd_valid ? next_rsp_rdata : 16'h0000;
      end
   end

endmodule

`default_nettype wire

// *** test/limit_fault_warning_monitor_properties.sv ***
// Port checker for the limit monitor, bound into the design
`timescale 1ns/100ps
`default_nettype none
module limit_monitor_checker (
   input wire logic       core_clk, rst, cmd_valid, cmd_write, iout_valid, temp_valid, vin_valid, unit_enabled,
   input wire logic       alert_n, warn_notify, fault_notify, sync_rect_inhibit, output_inhibit,
   input wire logic [7:0] cmd_code
);
   // ************************************************************
   // Status, alert and action relations
   // ************************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire clr = cmd_valid && cmd_write && cmd_code == limit_monitor_pkg::CMD_CLEAR_FAULTS;
   wire smp = iout_valid || temp_valid || vin_valid;
   chk_clear_release: assert property (clr && !smp |=> alert_n) else $error("alert kept");
   chk_alert_sticky: assert property (!alert_n && !clr |=> !alert_n) else $error("alert dropped");
   chk_set_notifies: assert property ($fell(alert_n) |-> warn_notify || fault_notify) else $error("no notify");
   chk_set_by_sample: assert property ($fell(alert_n) |-> $past(smp)) else $error("set, no sample");
   chk_notify_alert: assert property (warn_notify || fault_notify |-> !alert_n) else $error("no alert");
   chk_out_hold: assert property (output_inhibit && unit_enabled |=> output_inhibit) else $error("lost");
   chk_rect_hold: assert property (sync_rect_inhibit && unit_enabled |=> sync_rect_inhibit) else $error("lost");
   chk_rect_only: assert property ($rose(sync_rect_inhibit) && !$past(temp_valid) && !$past(vin_valid)
      |-> !$rose(output_inhibit)) else $error("output shut by sink fault");
endmodule
bind limit_fault_warning_monitor limit_monitor_checker chk (.*);
`default_nettype wire

// *** test/mgmt_host_model.sv ***
// Management host model that issues commands and collects answers
`timescale 1ns/100ps
`default_nettype none
module mgmt_host_model (
   input  wire logic        core_clk,
   input  wire logic        rsp_valid,
   input  wire logic        rsp_error,
   input  wire logic [15:0] rsp_rdata,
   output var  logic        cmd_valid,
   output var  logic        cmd_write,
   output var  logic [7:0]  cmd_code,
   output var  logic [15:0] cmd_wdata
);
   // ************************************************************
   // Command transfer
   // ************************************************************
   initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = '0;
   // Released data is inverted so a stale word is never mistaken for a live one
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q, output logic e);
      @(posedge core_clk);
      {cmd_valid, cmd_write, cmd_code, cmd_wdata} <= {1'b1, w, c, d};
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      cmd_wdata <= ~d;
      @(negedge core_clk);
      q = rsp_rdata;
      e = rsp_error | ~rsp_valid;
   endtask
endmodule
`default_nettype wire

// *** test/limit_fault_warning_monitor_tb.sv ***
// Self-checking bench for the limit monitor
`timescale 1ns/100ps
`default_nettype none
module limit_fault_warning_monitor_tb;
   typedef struct packed {logic [7:0] lc; logic [15:0] lim; logic ae; logic [7:0] act; logic [1:0] g;
      logic [15:0] v; logic [3:0] b; logic f; logic [1:0] inh;} scen_s;
   logic        core_clk = 1'b0, rst = 1'b1, unit_enabled = 1'b0, vin_above_on = 1'b0, e;
   logic        cmd_valid, cmd_write, rsp_valid, rsp_error, alert_n, warn_notify, fault_notify;
   logic        sync_rect_inhibit, output_inhibit;
   logic [2:0]  vld = 3'h0;
   logic [1:0]  seen;
   logic [7:0]  cmd_code;
   logic [15:0] smpl = 16'h0000, q, d, cmd_wdata, rsp_rdata;
   int          num_errors = 0, total_checks = 0, cyc = 0;
   scen_s       tbl[10];
   // ************************************************************
   // Clock, instances and timeout
   // ************************************************************
   always #25 core_clk = ~core_clk;
   mgmt_host_model host (.core_clk(core_clk), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
   limit_fault_warning_monitor uut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
      .iout_valid(vld[0]), .iout_sample(smpl), .temp_valid(vld[1]), .temp_sample(smpl), .vin_valid(vld[2]),
      .vin_sample(smpl), .vin_above_on(vin_above_on), .unit_enabled(unit_enabled), .alert_n(alert_n),
      .warn_notify(warn_notify), .fault_notify(fault_notify), .sync_rect_inhibit(sync_rect_inhibit),
      .output_inhibit(output_inhibit));
   always @(posedge core_clk) begin
      seen <= rst ? 2'h0 : seen | {warn_notify, fault_notify};
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      host.xfer(1'b1, c, v, q, e);
   endtask
   task automatic rd(input logic [7:0] c);
      host.xfer(1'b0, c, 16'h0000, q, e);
   endtask
   task automatic put(input logic [1:0] g, input logic [15:0] v);
      @(posedge core_clk);
      vld <= 3'h1 << g;
      smpl <= v;
      @(posedge core_clk);
      vld <= 3'h0;
      @(posedge core_clk);
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      rst <= 1'b1;
      unit_enabled <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   function automatic logic [15:0] exp_word(input logic [1:0] g);
      return (g == 2'h1) ? 16'h0004 : ((g == 2'h0) ? 16'h4001 : 16'h2001);
   endfunction
   // ************************************************************
   // Trip, hold, clear sequence for one limit
   // ************************************************************
   task automatic run(input scen_s s);
      do_reset();
      vin_above_on <= 1'b1;
      wr(s.lc, s.lim);
      if (s.ae) wr(s.lc + 8'h01, {8'h00, s.act});
      if (s.g == 2'h2 && s.b < 4'h6) begin
         put(s.g, s.v);
         cmp({15'h0000, alert_n}, 16'h0001);
      end
      unit_enabled <= 1'b1;
      put(s.g, s.v);
      put(s.g, s.lim);
      rd(limit_monitor_pkg::CMD_STATUS_IOUT + {6'h00, s.g});
      cmp(q, 16'h0001 << s.b);
      rd(limit_monitor_pkg::CMD_STATUS_WORD);
      cmp(q, exp_word(s.g));
      cmp({14'h0000, seen}, s.f ? 16'h0001 : 16'h0002);
      cmp({14'h0000, sync_rect_inhibit, output_inhibit}, {14'h0000, s.inh});
      wr(limit_monitor_pkg::CMD_CLEAR_FAULTS, 16'h0000);
      rd(limit_monitor_pkg::CMD_STATUS_IOUT + {6'h00, s.g});
      cmp({q[14:0], alert_n}, 16'h0001);
      put(s.g, s.v);
      cmp({15'h0000, alert_n}, 16'h0000);
   endtask
   initial begin
      void'($urandom(32'h372b));
      tbl = '{'{limit_monitor_pkg::CMD_IOUT_OC_WARN_LIM, 16'h0064, '0, '0, 2'h0, 16'h0065, 4'h5, '0, '0},
         '{limit_monitor_pkg::CMD_IOUT_SINK_FLT_LIM, 16'hff9c, '1, 8'h80, 2'h0, 16'hff38, 4'h4, '1, 2'h2},
         '{limit_monitor_pkg::CMD_OT_FLT_LIM, 16'h0064, '1, 8'h40, 2'h1, 16'h0065, 4'h7, '1, 2'h1},
         '{limit_monitor_pkg::CMD_OT_WARN_LIM, 16'h0050, '0, '0, 2'h1, 16'h0051, 4'h6, '0, '0},
         '{limit_monitor_pkg::CMD_UT_WARN_LIM, 16'hfff6, '0, '0, 2'h1, 16'hffec, 4'h5, '0, '0},
         '{limit_monitor_pkg::CMD_UT_FLT_LIM, 16'hfff6, '1, 8'h00, 2'h1, 16'hffec, 4'h4, '1, '0},
         '{limit_monitor_pkg::CMD_VIN_OV_FLT_LIM, 16'h1000, '1, 8'hc0, 2'h2, 16'h1001, 4'h7, '1, 2'h1},
         '{limit_monitor_pkg::CMD_VIN_HI_WARN_LIM, 16'h1000, '0, '0, 2'h2, 16'h1001, 4'h6, '0, '0},
         '{limit_monitor_pkg::CMD_VIN_LO_WARN_LIM, 16'h1000, '0, '0, 2'h2, 16'h0fff, 4'h5, '0, '0},
         '{limit_monitor_pkg::CMD_VIN_UV_FLT_LIM, 16'h1000, '0, '0, 2'h2, 16'h0fff, 4'h4, '1, '0}};
      do_reset();
      rd(limit_monitor_pkg::CMD_IOUT_SINK_FLT_LIM);
      cmp(q, 16'h0000);
      foreach (tbl[i]) begin
         d = 16'($urandom);
         wr(tbl[i].lc, d);
         rd(tbl[i].lc);
         cmp(q, d);
      end
      wr(limit_monitor_pkg::CMD_STATUS_BYTE, d);
      cmp({15'h0000, e}, 16'h0001);
      rd(limit_monitor_pkg::CMD_CLEAR_FAULTS);
      cmp({15'h0000, e}, 16'h0001);
      foreach (tbl[i]) run(tbl[i]);
      conclude();
   end
endmodule
`default_nettype wire
